// >>> inc/tsr_pkg.sv
// package: constants for the target selection / response logic
package tsr_pkg;
  // selection record word offsets
  localparam logic [7:0] SEL_OFS_IDENT = 8'h00;
  localparam logic [7:0] SEL_OFS_FLAGS = 8'h04;
  localparam logic [7:0] SEL_OFS_MSG = 8'h08;
  localparam logic [7:0] SEL_OFS_TAG = 8'h0C;
  localparam logic [7:0] SEL_OFS_CDB0 = 8'h10;
  localparam logic [7:0] SEL_OFS_CDB1 = 8'h14;
  localparam logic [7:0] SEL_OFS_CDB2 = 8'h18;
  localparam logic [7:0] SEL_OFS_SEMA = 8'h1C;
  localparam logic [7:0] SEL_LAST_OFS = 8'h1C;
  localparam logic [7:0] WORD_STEP = 8'h04;
  // response parameter block word offsets
  localparam logic [7:0] RSP_OFS_IDENT = 8'h00;
  localparam logic [7:0] RSP_OFS_OPT = 8'h04;
  localparam logic [7:0] RSP_OFS_ADDR = 8'h08;
  localparam logic [7:0] RSP_OFS_COUNT = 8'h0C;
  localparam logic [7:0] RSP_OFS_CTRL = 8'h10;
  localparam logic [7:0] RSP_OFS_TAG = 8'h14;
  localparam logic [7:0] RSP_LAST_OFS = 8'h14;
  // option byte bit positions
  localparam int OPT_DIR_BIT = 1;
  localparam int OPT_XFER_BIT = 2;
  localparam int OPT_TGT_BIT = 4;
  localparam int OPT_ICC_BIT = 5;
  // scsi flags bit positions
  localparam int SF_CMD_BIT = 3;
  localparam int SF_MSG_BIT = 2;
  // special values
  localparam logic [3:0] SEQ_AFTER_SELECT = 4'h5;
  localparam logic [7:0] ERR_NO_SELECT_INFO = 8'h33;
  localparam logic [7:0] TAG_MSG_NONE = 8'h00;
  localparam logic [7:0] ATTN_RELEASE = 8'h02;
  localparam logic [2:0] IRQ_LEVEL_OFF = 3'h0;
  localparam logic [7:0] SEMA_VALID = 8'h01;
  localparam logic [3:0] CDB_MAX = 4'hC;
  localparam logic [7:0] FLAG_TME = 8'h01;
  localparam logic [7:0] FLAG_CC = 8'h80;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
endpackage

// >>> hw/tsr_core.sv
// target selection reporting and response command decode
`timescale 1ns/1ps
// ----------------------------------------------------------------
// How it works
// R1: report identify byte; invalid if seq 5/33H
// R2: record initiator id; invalid on error 33H
// R3: write command length; valid with command flag
// R4: record message byte, valid with message flag
// R5: record queue tag id and tag message
// R6: twelve byte command area, length bytes valid
// R7: set semaphore then irq unless level zero
// R8: host zeroes record after reading it
// R9: no new record until attention value 2
// R10: host issues responses from command list only
// R11: queue response commands like initiator commands
// R12: always accept unexpected message into status
// R13: response parameter block word layout
// R14: host gives unique identifier per command
// R15: reselect given initiator with identify lun
// R16: drive block address modifier on bus
// R17: option bit 1 picks data direction
// R18: option bit 2 requests a data phase
// R19: option bit 4 marks target response
// R20: option bit 5 suppresses completion interrupt
// R21: buffer address used only with data phase
// R22: transfer count bytes; zero means 4G
// R23: command flag set when command received
// R24: message flag set when message valid
// R25: reserved block bits ignored
// ----------------------------------------------------------------
module tsr_core (
  input wire logic mclk, // 50 MHz clock
  input wire logic rstn, // sync reset, active low
  // selection capture from scsi engine
  input wire logic sel_evt, // one-cycle selection report
  input wire logic [31:0] sel_ident, // target enable command identifier
  input wire logic [7:0] sel_status_flags, // selection flags byte
  input wire logic [7:0] sel_error, // error code
  input wire logic [3:0] sel_seq_code, // error sequence code
  input wire logic sel_disc, // disconnected flag
  input wire logic sel_chk, // check condition sent
  input wire logic sel_msg_valid, // message byte was received
  input wire logic [7:0] sel_msg_byte, // received message byte
  input wire logic [3:0] sel_cdb_len, // command bytes received
  input wire logic [95:0] sel_cdb, // command bytes, byte 0 low
  input wire logic [7:0] sel_init_id, // selecting initiator id
  input wire logic [7:0] sel_ident_msg, // last identify message
  input wire logic [7:0] sel_tag_msg, // queue tag message
  input wire logic [7:0] sel_tag_id, // queue tag identifier
  output logic sel_ready, // record area free
  // host memory write port for selection record
  output logic mw_valid, // memory write request
  input wire logic mw_ready, // memory write accepted
  output logic [7:0] mw_ofs, // byte offset within record
  output logic [31:0] mw_data, // word to write
  // host channel attention and config
  input wire logic attn_wr, // channel attention write pulse
  input wire logic [7:0] attn_val, // channel attention value
  input wire logic [2:0] sel_irq_level, // selection interrupt level
  output logic sel_irq, // selection interrupt pulse
  output logic rec_valid_ident, // identify byte valid
  output logic rec_valid_init, // initiator id valid
  output logic rec_valid_tag, // queue tag id valid
  // response parameter block, one word per beat
  input wire logic pb_valid, // parameter word valid
  output logic pb_ready, // parameter word taken
  input wire logic [7:0] pb_ofs, // word offset
  input wire logic [31:0] pb_data, // parameter word
  // decoded response command
  output logic cmd_valid, // decoded command ready
  input wire logic cmd_ready, // engine takes command
  output logic [31:0] cmd_ident, // command identifier
  output logic [7:0] cmd_init_id, // initiator to reselect
  output logic [7:0] cmd_lun, // lun to reselect
  output logic [5:0] cmd_addr_mod, // bus address modifier
  output logic [31:0] cmd_addr, // host buffer start
  output logic [32:0] cmd_count, // bytes, zero expanded
  output logic cmd_xfer, // data phase wanted
  output logic cmd_to_init, // data goes to initiator
  output logic cmd_target, // target response command
  output logic cmd_irq_en, // completion interrupt wanted
  output logic [7:0] cmd_ctrl, // response control flags
  output logic [7:0] cmd_tag_msg, // queue tag message
  output logic [7:0] cmd_tag_id, // queue tag id
  output logic [7:0] cmd_status, // status or first message
  output logic [7:0] cmd_msg, // message byte
  // unexpected message into status
  input wire logic umsg_evt, // unexpected message pulse
  input wire logic [7:0] umsg_byte, // message from initiator
  output logic [7:0] stat_msg_rcvd, // status block message byte
  output logic stat_msg_flag // message captured flag
);

  // ----------------------------------------------------------------
  // selection record writer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {TSR_IDLE, TSR_WRITE, TSR_HOLD} tsr_state_t;
  tsr_state_t state_ff;
  tsr_state_t nxt_state;
  logic [7:0] ofs_ff;
  logic [31:0] ident_ff;
  logic [7:0] sflags_ff;
  logic [7:0] err_ff;
  logic [7:0] flags_ff;
  logic [7:0] msg_ff;
  logic [3:0] len_ff;
  logic [7:0] init_ff;
  logic [7:0] idm_ff;
  logic [7:0] tmsg_ff;
  logic [7:0] tid_ff;
  logic [95:0] cdb_ff;
  logic irq_ff;
  logic [3:0] len_clip;
  logic [95:0] cdb_mask;
  logic release_hit;

  // clip length to the command area
  assign len_clip = (sel_cdb_len > tsr_pkg::CDB_MAX) ? tsr_pkg::CDB_MAX : sel_cdb_len;
  assign release_hit = attn_wr && (attn_val == tsr_pkg::ATTN_RELEASE);

  // zero command bytes beyond the length
  always_comb begin
    cdb_mask = '0;
    for (int i = 0; i < 12; i++) begin
      if (4'(i) < len_clip) begin
        cdb_mask[i*8 +: 8] = 8'hFF; // R6
      end
    end
  end

  // capture selection data
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ident_ff <= tsr_pkg::RESET_WORD;
      sflags_ff <= 8'h00;
      err_ff <= 8'h00;
      flags_ff <= 8'h00;
      msg_ff <= 8'h00;
      len_ff <= 4'h0;
      init_ff <= 8'h00;
      idm_ff <= 8'h00;
      tmsg_ff <= 8'h00;
      tid_ff <= 8'h00;
      cdb_ff <= '0;
    end else if (state_ff == TSR_IDLE && sel_evt) begin
      ident_ff <= sel_ident;
      sflags_ff <= {sel_seq_code, len_clip != 4'h0, sel_msg_valid, sel_chk, sel_disc}; // R23 R24
      err_ff <= sel_error;
      flags_ff <= sel_status_flags;
      msg_ff <= sel_msg_valid ? sel_msg_byte : 8'h00; // R4
      len_ff <= len_clip; // R3
      init_ff <= sel_init_id; // R2
      idm_ff <= sel_ident_msg; // R1
      tmsg_ff <= sel_tag_msg; // R5
      tid_ff <= sel_tag_id; // R5
      cdb_ff <= sel_cdb & cdb_mask; // R6
    end
  end

  // record validity views
  assign rec_valid_ident = (sflags_ff[7:4] != tsr_pkg::SEQ_AFTER_SELECT) &&
                           (err_ff != tsr_pkg::ERR_NO_SELECT_INFO); // R1
  assign rec_valid_init = err_ff != tsr_pkg::ERR_NO_SELECT_INFO; // R2
  assign rec_valid_tag = tmsg_ff != tsr_pkg::TAG_MSG_NONE; // R5

  // word mux: semaphore word written last
  always_comb begin
    if (ofs_ff == tsr_pkg::SEL_OFS_IDENT) begin
      mw_data = ident_ff;
    end else if (ofs_ff == tsr_pkg::SEL_OFS_FLAGS) begin
      mw_data = {flags_ff, err_ff, 8'h00, sflags_ff};
    end else if (ofs_ff == tsr_pkg::SEL_OFS_MSG) begin
      mw_data = {idm_ff, init_ff, 4'h0, len_ff, msg_ff};
    end else if (ofs_ff == tsr_pkg::SEL_OFS_TAG) begin
      mw_data = {16'h0000, tid_ff, tmsg_ff};
    end else if (ofs_ff == tsr_pkg::SEL_OFS_CDB0) begin
      mw_data = cdb_ff[31:0];
    end else if (ofs_ff == tsr_pkg::SEL_OFS_CDB1) begin
      mw_data = cdb_ff[63:32];
    end else if (ofs_ff == tsr_pkg::SEL_OFS_CDB2) begin
      mw_data = cdb_ff[95:64];
    end else begin
      mw_data = {tsr_pkg::SEMA_VALID, 24'h000000}; // R7
    end
  end

  assign mw_valid = state_ff == TSR_WRITE;
  assign mw_ofs = ofs_ff;
  assign sel_ready = state_ff == TSR_IDLE;
  assign sel_irq = irq_ff;

  // next state of record writer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      TSR_IDLE: begin
        if (sel_evt) begin
          nxt_state = TSR_WRITE;
        end
      end
      TSR_WRITE: begin
        if (mw_ready && ofs_ff == tsr_pkg::SEL_LAST_OFS) begin
          nxt_state = TSR_HOLD;
        end
      end
      default: begin
        if (release_hit) begin
          nxt_state = TSR_IDLE; // R9
        end
      end
    endcase
  end

  // state, offset walk and interrupt
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_ff <= TSR_IDLE;
      ofs_ff <= tsr_pkg::SEL_OFS_IDENT;
      irq_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      irq_ff <= 1'b0;
      if (state_ff == TSR_IDLE) begin
        ofs_ff <= tsr_pkg::SEL_OFS_IDENT;
      end else if (state_ff == TSR_WRITE && mw_ready) begin
        ofs_ff <= ofs_ff + tsr_pkg::WORD_STEP;
        if (ofs_ff == tsr_pkg::SEL_LAST_OFS) begin
          irq_ff <= sel_irq_level != tsr_pkg::IRQ_LEVEL_OFF; // R7
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // response parameter block decode
  // ----------------------------------------------------------------
  logic cmd_full_ff;
  logic [7:0] opt_ff;
  logic [31:0] cnt_ff;
  logic [31:0] addr_ff;
  logic pb_last;

  assign pb_ready = !cmd_full_ff; // R11
  assign pb_last = pb_valid && pb_ready && pb_ofs == tsr_pkg::RSP_LAST_OFS;
  assign cmd_valid = cmd_full_ff;

  // gather block words, reserved fields dropped
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cmd_ident <= tsr_pkg::RESET_WORD;
      cmd_lun <= 8'h00;
      opt_ff <= 8'h00;
      cmd_addr_mod <= 6'h00;
      cmd_init_id <= 8'h00;
      addr_ff <= tsr_pkg::RESET_WORD;
      cnt_ff <= tsr_pkg::RESET_WORD;
      cmd_ctrl <= 8'h00;
      cmd_tag_msg <= 8'h00;
      cmd_tag_id <= 8'h00;
      cmd_status <= 8'h00;
      cmd_msg <= 8'h00;
    end else if (pb_valid && pb_ready) begin
      if (pb_ofs == tsr_pkg::RSP_OFS_IDENT) begin
        cmd_ident <= pb_data; // R13
      end else if (pb_ofs == tsr_pkg::RSP_OFS_OPT) begin
        cmd_lun <= pb_data[7:0]; // R15
        opt_ff <= pb_data[15:8];
        cmd_addr_mod <= pb_data[21:16]; // R16
        cmd_init_id <= pb_data[31:24]; // R15
      end else if (pb_ofs == tsr_pkg::RSP_OFS_ADDR) begin
        addr_ff <= pb_data;
      end else if (pb_ofs == tsr_pkg::RSP_OFS_COUNT) begin
        cnt_ff <= pb_data;
      end else if (pb_ofs == tsr_pkg::RSP_OFS_CTRL) begin
        cmd_ctrl <= pb_data[23:16]; // R25
      end else if (pb_ofs == tsr_pkg::RSP_OFS_TAG) begin
        cmd_tag_msg <= pb_data[7:0];
        cmd_tag_id <= pb_data[15:8];
        cmd_status <= pb_data[23:16];
        cmd_msg <= pb_data[31:24];
      end
    end
  end

  // hold one decoded command until the engine takes it
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cmd_full_ff <= 1'b0;
    end else if (pb_last) begin
      cmd_full_ff <= 1'b1; // R11
    end else if (cmd_ready) begin
      cmd_full_ff <= 1'b0;
    end
  end

  // option decode
  assign cmd_xfer = opt_ff[tsr_pkg::OPT_XFER_BIT]; // R18
  assign cmd_to_init = cmd_xfer && opt_ff[tsr_pkg::OPT_DIR_BIT]; // R17
  assign cmd_target = opt_ff[tsr_pkg::OPT_TGT_BIT]; // R19
  assign cmd_irq_en = !opt_ff[tsr_pkg::OPT_ICC_BIT]; // R20
  assign cmd_addr = cmd_xfer ? addr_ff : tsr_pkg::RESET_WORD; // R21
  assign cmd_count = (cnt_ff == tsr_pkg::RESET_WORD) ? {1'b1, 32'h0000_0000} : {1'b0, cnt_ff}; // R22

  // ----------------------------------------------------------------
  // unexpected message capture, set wins over clear
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      stat_msg_rcvd <= 8'h00;
      stat_msg_flag <= 1'b0;
    end else if (umsg_evt) begin
      stat_msg_rcvd <= umsg_byte; // R12
      stat_msg_flag <= 1'b1; // R24
    end else if (pb_last) begin
      stat_msg_flag <= 1'b0;
    end
  end

endmodule

// >>> dv/tsr_host_model.sv
// host memory model taking selection record writes
`timescale 1ns/1ps
module tsr_host_model (
  input wire logic mclk, // clock
  input wire logic slow, // stall writes
  input wire logic ack, // host done with record
  input wire logic [7:0] ack_val, // attention value
  input wire logic mw_valid, // write request
  output logic mw_ready, // write taken
  input wire logic [7:0] mw_ofs, // byte offset
  input wire logic [31:0] mw_data, // record word
  output logic attn_wr = 1'b0, // attention pulse
  output logic [7:0] attn_val = 8'h00 // attention value
);
  logic [31:0] mem [8];
  logic [1:0] cnt_ff = 2'h0;
  // one write in three accepted when slow
  assign mw_ready = !slow || cnt_ff == 2'h0;
  // store words, zero record and raise attention on ack
  always @(posedge mclk) begin
    cnt_ff <= (cnt_ff == 2'h2) ? 2'h0 : cnt_ff + 2'h1;
    if (mw_valid && mw_ready) mem[mw_ofs[4:2]] <= mw_data;
    if (ack) mem <= '{default: 32'h0};
    attn_wr <= ack;
    attn_val <= ack ? ack_val : ~attn_val;
  end
endmodule

// >>> dv/tsr_properties.sv
// assertions on the target selection / response ports
`timescale 1ns/1ps
module tsr_props (
  input wire logic mclk, // clock
  input wire logic rstn, // reset, active low
  input wire logic sel_ready, // record free
  input wire logic mw_valid, // write request
  input wire logic mw_ready, // write taken
  input wire logic [7:0] mw_ofs, // record offset
  input wire logic [31:0] mw_data, // record word
  input wire logic attn_wr, // attention pulse
  input wire logic [7:0] attn_val, // attention value
  input wire logic [2:0] sel_irq_level, // irq level
  input wire logic sel_irq, // selection irq
  input wire logic rec_valid_ident, // identify valid
  input wire logic rec_valid_init, // initiator valid
  input wire logic rec_valid_tag, // tag valid
  input wire logic pb_valid, // block word valid
  input wire logic pb_ready, // block word taken
  input wire logic [7:0] pb_ofs, // block offset
  input wire logic cmd_valid, // command ready
  input wire logic [32:0] cmd_count, // byte count
  input wire logic umsg_evt, // unexpected message
  input wire logic [7:0] umsg_byte, // message byte
  input wire logic [7:0] stat_msg_rcvd, // status message
  input wire logic stat_msg_flag // message flag
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // semaphore word taken by host
  sequence s_sema_take;
    mw_valid && mw_ready && mw_ofs == 8'h1C;
  endsequence
  a_sema_irq: assert property (s_sema_take ##0 sel_irq_level != 3'h0 |=> sel_irq)
    else $error("selection irq missing after semaphore");
  a_irq_level_off: assert property (s_sema_take ##0 sel_irq_level == 3'h0 |=> !sel_irq)
    else $error("selection irq raised at level zero");
  a_sema_word: assert property (mw_valid && mw_ofs == 8'h1C |-> mw_data == 32'h0100_0000)
    else $error("semaphore word wrong");
  a_hold_record: assert property (!sel_ready && !mw_valid && !(attn_wr && attn_val == 8'h02) |=> !sel_ready)
    else $error("record freed without attention");
  a_attn_free: assert property (!sel_ready && !mw_valid && attn_wr && attn_val == 8'h02 |=> sel_ready)
    else $error("attention did not free record");
  a_ident_valid: assert property (mw_valid && mw_ofs == 8'h04 |->
    rec_valid_ident == !(mw_data[7:4] == 4'h5 || mw_data[23:16] == 8'h33))
    else $error("identify valid wrong");
  a_init_valid: assert property (mw_valid && mw_ofs == 8'h04 |-> rec_valid_init == (mw_data[23:16] != 8'h33))
    else $error("initiator valid wrong");
  a_tag_valid: assert property (mw_valid && mw_ofs == 8'h0C |-> rec_valid_tag == (mw_data[7:0] != 8'h00))
    else $error("tag valid wrong");
  a_block_done: assert property (pb_valid && pb_ready && pb_ofs == 8'h14 |=> cmd_valid && !pb_ready)
    else $error("block end gave no command");
  a_umsg_load: assert property (umsg_evt |=> stat_msg_flag && stat_msg_rcvd == $past(umsg_byte))
    else $error("unexpected message lost");
  a_count_zero: assert property (cmd_valid |-> cmd_count[32] == (cmd_count[31:0] == 32'h0))
    else $error("zero count not expanded");
endmodule
bind tsr_core tsr_props i_props (.*);

// >>> dv/tb.sv
// self-checking bench for the target selection / response logic
`timescale 1ns/1ps
module tb;
  logic mclk = 1'b0, rstn = 1'b0, slow = 1'b0, ack = 1'b0;
  logic [7:0] ack_val = 8'h00;
  logic sel_evt, sel_disc, sel_chk, sel_msg_valid, sel_ready, mw_valid, mw_ready, attn_wr, sel_irq;
  logic rec_valid_ident, rec_valid_init, rec_valid_tag, pb_valid, pb_ready, cmd_valid, cmd_ready;
  logic cmd_xfer, cmd_to_init, cmd_target, cmd_irq_en, umsg_evt, stat_msg_flag;
  logic [31:0] sel_ident, mw_data, pb_data, cmd_ident, cmd_addr;
  logic [7:0] sel_status_flags, sel_error, sel_msg_byte, sel_init_id, sel_ident_msg, sel_tag_msg, sel_tag_id;
  logic [7:0] mw_ofs, attn_val, pb_ofs, cmd_init_id, cmd_lun, cmd_ctrl, cmd_tag_msg, cmd_tag_id, cmd_status;
  logic [7:0] cmd_msg, umsg_byte, stat_msg_rcvd;
  logic [3:0] sel_seq_code, sel_cdb_len;
  logic [95:0] sel_cdb;
  logic [2:0] sel_irq_level;
  logic [5:0] cmd_addr_mod;
  logic [32:0] cmd_count;
  logic [31:0] w [6];
  logic [3:0] lens [5] = '{4'h0, 4'h6, 4'hA, 4'hC, 4'hF};
  int num_errors = 0, check_count = 0, cyc = 0;
  tsr_core i_tsr_core (.*);
  tsr_host_model i_tsr_host_model (.*);
  // clock and hang guard
  initial forever #10 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      close_out();
    end
  end
  task automatic chk(input string n, input logic [32:0] e, input logic [32:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge mclk);
    s = 1'b0;
  endtask
  // expected record word k from held selection inputs
  function automatic logic [31:0] rec_word(input int k);
    logic [3:0] n;
    logic [31:0] r;
    n = (sel_cdb_len > 4'hC) ? 4'hC : sel_cdb_len;
    r = 32'h0;
    case (k)
      0: r = sel_ident;
      1: r = {sel_status_flags, sel_error, 8'h00, sel_seq_code, n != 4'h0, sel_msg_valid, sel_chk, sel_disc};
      2: r = {sel_ident_msg, sel_init_id, 4'h0, n, sel_msg_byte};
      3: r = {16'h0000, sel_tag_id, sel_tag_msg};
      7: r = 32'h0100_0000;
      default: for (int b = 0; b < 4; b++) if ((k - 4) * 4 + b < n) r[8*b +: 8] = sel_cdb[8*((k-4)*4+b) +: 8];
    endcase
    return r;
  endfunction
  task automatic sel_tests();
    logic [31:0] m;
    for (int i = 0; i < 10; i++) begin
      sel_ident = $urandom;
      {sel_error, sel_status_flags, sel_msg_byte, sel_init_id} = $urandom;
      {sel_ident_msg, sel_tag_msg, sel_tag_id, sel_disc, sel_chk, sel_msg_valid} = 27'($urandom);
      sel_cdb = {$urandom, $urandom, $urandom};
      sel_seq_code = 4'($urandom_range(9));
      sel_cdb_len = (i < 5) ? lens[i] : 4'($urandom);
      if (i == 1) sel_error = 8'h33;
      if (i == 2) sel_seq_code = 4'h5;
      if (i == 3) sel_tag_msg = 8'h00;
      sel_irq_level = (i == 4) ? 3'h0 : 3'($urandom);
      slow = i[0];
      pulse(sel_evt);
      for (int t = 0; t < 100 && !(mw_valid && mw_ready && mw_ofs == 8'h1C); t++) @(negedge mclk);
      @(negedge mclk);
      chk("sel_irq", sel_irq_level != 3'h0, sel_irq);
      for (int k = 0; k < 8; k++) begin
        m = (k == 2 && !sel_msg_valid) ? 32'hFFFF_FF00 : 32'hFFFF_FFFF;
        chk("record word", rec_word(k) & m, i_tsr_host_model.mem[k] & m);
      end
      chk("ident valid", !(sel_seq_code == 4'h5 || sel_error == 8'h33), rec_valid_ident);
      chk("init valid", sel_error != 8'h33, rec_valid_init);
      chk("tag valid", sel_tag_msg != 8'h00, rec_valid_tag);
      pulse(sel_evt);
      repeat (2) @(negedge mclk);
      chk("refused write", 1'b0, mw_valid);
      ack_val = 8'h03;
      pulse(ack);
      repeat (3) @(negedge mclk);
      chk("ready held", 1'b0, sel_ready);
      ack_val = 8'h02;
      pulse(ack);
      repeat (3) @(negedge mclk);
      chk("ready freed", 1'b1, sel_ready);
    end
  endtask
  task automatic pb_send(input logic [7:0] o, input logic [31:0] d);
    pb_valid = 1'b1;
    pb_ofs = o;
    pb_data = d;
    while (pb_ready !== 1'b1) @(negedge mclk);
    @(negedge mclk);
  endtask
  task automatic pb_tests();
    logic [7:0] opt;
    for (int i = 0; i < 8; i++) begin
      opt = {2'b00, i[2:1], 1'b0, i[0], 1'($urandom), 1'b0};
      w[0] = 32'hA000_0000 + i;
      w[1] = {8'($urandom), 2'b00, 6'($urandom), opt, 8'($urandom)};
      w[2] = $urandom;
      w[3] = (i == 3) ? 32'h0 : $urandom;
      w[4] = {8'h00, 8'($urandom), 16'h0000};
      w[5] = $urandom;
      if (i == 1) begin
        umsg_byte = 8'($urandom);
        pulse(umsg_evt);
        chk("umsg flag", 1'b1, stat_msg_flag);
        chk("umsg byte", umsg_byte, stat_msg_rcvd);
      end
      for (int k = 0; k < 6; k++) begin
        // closing word and a new message on one edge
        if (i == 2) umsg_evt = (k == 5);
        pb_send(8'(4 * k), w[k]);
      end
      if (i == 2) umsg_evt = 1'b0;
      pb_valid = 1'b0;
      if (i == 1) chk("umsg clear", 1'b0, stat_msg_flag);
      if (i == 2) chk("umsg set wins", 1'b1, stat_msg_flag);
      chk("cmd_valid", 1'b1, cmd_valid);
      chk("pb_ready", 1'b0, pb_ready);
      chk("init id", w[1][31:24], cmd_init_id);
      chk("lun", w[1][7:0], cmd_lun);
      chk("addr mod", w[1][21:16], cmd_addr_mod);
      chk("xfer", opt[2], cmd_xfer);
      chk("dir", opt[1] & opt[2], cmd_to_init & cmd_xfer);
      chk("target", opt[4], cmd_target);
      chk("irq en", !opt[5], cmd_irq_en);
      chk("addr", opt[2] ? w[2] : 32'h0, cmd_addr);
      chk("count", (w[3] == 32'h0) ? 33'h1_0000_0000 : {1'b0, w[3]}, cmd_count);
      chk("ctrl", w[4][23:16], cmd_ctrl);
      chk("tag words", w[5], {cmd_msg, cmd_status, cmd_tag_id, cmd_tag_msg});
      repeat (2) @(negedge mclk);
      chk("ident held", w[0], cmd_ident);
      pulse(cmd_ready);
      chk("pb free", 1'b1, pb_ready);
    end
  endtask
  // main sequence
  initial begin
    {sel_evt, sel_disc, sel_chk, sel_msg_valid, pb_valid, cmd_ready, umsg_evt} = '0;
    {sel_ident, sel_status_flags, sel_error, sel_seq_code, sel_msg_byte, sel_cdb_len, sel_cdb} = '0;
    {sel_init_id, sel_ident_msg, sel_tag_msg, sel_tag_id, sel_irq_level, pb_ofs, pb_data, umsg_byte} = '0;
    void'($urandom(32'hA666C9FA));
    repeat (6) @(negedge mclk);
    rstn = 1'b1;
    sel_tests();
    $display("selection tests done");
    pb_tests();
    $display("response tests done");
    close_out();
  end
endmodule
